// File: status_lamp_pkg.sv
// Package: constants and types for the status lamp driver
package status_lamp_pkg;

  // Clock rate and blink timing
  localparam int unsigned CLK_HZ = 250_000_000; // Board clock rate
  localparam int unsigned HEARTBEAT_PERIOD_MS = 1000; // Heartbeat full period
  localparam int unsigned FLASH_PERIOD_MS = 1000; // Flash full period (on+off)
  // Half periods in cycles, rounded down
  localparam int unsigned HEARTBEAT_HALF_CYC = (CLK_HZ / 1000) * (HEARTBEAT_PERIOD_MS / 2);
  localparam int unsigned FLASH_HALF_CYC = (CLK_HZ / 1000) * (FLASH_PERIOD_MS / 2);
  localparam int unsigned TIMER_W = 28; // Width of the half-period timers

  // Reset values
  localparam logic [TIMER_W-1:0] TIMER_RESET = 28'h0000000;

  // Colour of a bi-colour lamp
  typedef struct packed {
    logic red;   // Red element lit
    logic green; // Green element lit
  } lamp_type;

  // Module side conditions
  typedef struct packed {
    logic self_test;    // Self test in progress
    logic major_fault;  // Unrecoverable fault
    logic minor_fault;  // Recoverable fault
    logic standby;      // Configuration missing or bad
  } module_cond_type;

  // Network side conditions
  typedef struct packed {
    logic online;          // Duplicate address check passed
    logic group2_only;     // Slave supports only group 2 set
    logic allocated;       // Group 2 slave allocated to master
    logic conn_established;// At least one established connection
    logic io_timeout;      // An I/O connection timed out
    logic dup_address;     // Duplicate node address found
    logic bus_off;         // Controller in bus-off
  } network_cond_type;

  // Indication chosen for a lamp
  typedef enum logic [2:0] {
    IND_OFF,
    IND_GREEN,
    IND_FLASH_GREEN,
    IND_FLASH_RED,
    IND_RED,
    IND_RED_GREEN
  } indication_type;

endpackage : status_lamp_pkg

// File: status_lamp_viewer.sv
// Operator model: counts lit cycles of a bi-colour lamp over the last eight clocks
`timescale 1ns/10ps
module status_lamp_viewer (
  input wire logic ref_clk_i, // Board clock
  input wire status_lamp_pkg::lamp_type lamp_i, // Lamp being watched
  output logic [3:0] red_cnt_o, // Red lit cycles in window
  output logic [3:0] green_cnt_o, // Green lit cycles in window
  output logic [3:0] both_cnt_o // Both lit: looks amber, never expected
);
  logic [7:0] red_hist = 8'h00; // Red history
  logic [7:0] green_hist = 8'h00; // Green history
  // An eye sees a rate, not a phase, so only duty over one flash period is kept
  always_ff @(posedge ref_clk_i) begin
    red_hist <= {red_hist[6:0], lamp_i.red};
    green_hist <= {green_hist[6:0], lamp_i.green};
  end
  assign red_cnt_o = 4'($countones(red_hist));
  assign green_cnt_o = 4'($countones(green_hist));
  assign both_cnt_o = 4'($countones(red_hist & green_hist));
endmodule : status_lamp_viewer

// File: status_led_indicator_logic.sv
// Status lamp driver: heartbeat, module state and network state lamps
// Function
// - Heartbeat toggles about every half second while board runs and link healthy
// - Module lamp steady green when operational
// - Module lamp flashes green in standby
// - Minor fault flashes red, major fault steady red
// - Self test alternates both lamps red/green
// - Network lamp dark while not on-line, unless duplicate address or bus-off lights it steady red
// - On-line without connection flashes network green
// - Unallocated group 2 slave flashes network green
// - Established connection lights network steady green
// - I/O connection timeout flashes network red
`timescale 1ns/10ps
module status_led_indicator_logic #(
  parameter int unsigned HEARTBEAT_HALF = status_lamp_pkg::HEARTBEAT_HALF_CYC, // Heartbeat half period
  parameter int unsigned FLASH_HALF = status_lamp_pkg::FLASH_HALF_CYC // Flash half period
) (
  input wire logic ref_clk_i, // Board clock
  input wire logic rstn_i, // Asynchronous reset, active low
  input wire logic board_running_i, // Board firmware running
  input wire logic link_ok_i, // Link to inverter control healthy
  input wire status_lamp_pkg::module_cond_type module_cond_i, // Module conditions
  input wire status_lamp_pkg::network_cond_type network_cond_i, // Network conditions
  output logic heartbeat_lamp_o, // Single colour heartbeat lamp
  output status_lamp_pkg::lamp_type module_state_lamp_o, // Module state lamp
  output status_lamp_pkg::lamp_type network_state_lamp_o // Network state lamp
);

  // Timing overview
  // Both half-period timers count from zero up to their last value and wrap.
  // The flash phase flips on each wrap, so a full flash period spans two
  // half periods and every flashing lamp shows an even on/off duty.
  // One phase bit serves both bi-colour lamps; lamps that flash at once
  // therefore always flash in step, which an operator reads more easily.
  // The heartbeat timer only advances while the board runs and its link to
  // the inverter control is healthy. Otherwise timer and level freeze, so
  // the lamp stays lit or dark as it was when the link dropped.
  // Lamp colours are painted into flip-flops one clock after the inputs are
  // sampled; the one clock of latency buys glitch-free lamp drive.
  // Inputs are levels; no condition is latched, so a lamp follows its
  // conditions as soon as they change and forgets them once they clear.

  // Whole state of the block
  typedef struct packed {
    logic [status_lamp_pkg::TIMER_W-1:0] beat_timer; // Heartbeat half-period counter
    logic [status_lamp_pkg::TIMER_W-1:0] flash_timer; // Shared flash counter
    logic beat; // Heartbeat lamp level
    logic phase; // Shared flash phase
    status_lamp_pkg::lamp_type module_lamp; // Registered module lamp
    status_lamp_pkg::lamp_type network_lamp; // Registered network lamp
  } state_type;

  state_type state; // Registered state
  state_type next_state; // Next state
  status_lamp_pkg::indication_type module_state_indication; // Module decode
  status_lamp_pkg::indication_type network_state_indication; // Network decode

  localparam logic [status_lamp_pkg::TIMER_W-1:0] BEAT_LAST = status_lamp_pkg::TIMER_W'(HEARTBEAT_HALF - 1);
  localparam logic [status_lamp_pkg::TIMER_W-1:0] FLASH_LAST = status_lamp_pkg::TIMER_W'(FLASH_HALF - 1);

  // Turn an indication into lamp colours using the shared phase
  // Every flashing pattern reads the same phase bit, so during self test
  // both lamps alternate red and green in lockstep.
  function automatic status_lamp_pkg::lamp_type paint(input status_lamp_pkg::indication_type ind,
                                                      input logic ph);
    status_lamp_pkg::lamp_type l;
    l = '{red: 1'b0, green: 1'b0};
    unique case (ind)
      status_lamp_pkg::IND_OFF: begin
        l = '{red: 1'b0, green: 1'b0};
      end
      status_lamp_pkg::IND_GREEN: begin
        l = '{red: 1'b0, green: 1'b1};
      end
      status_lamp_pkg::IND_FLASH_GREEN: begin
        l = '{red: 1'b0, green: ph};
      end
      status_lamp_pkg::IND_FLASH_RED: begin
        l = '{red: ph, green: 1'b0};
      end
      status_lamp_pkg::IND_RED: begin
        l = '{red: 1'b1, green: 1'b0};
      end
      status_lamp_pkg::IND_RED_GREEN: begin
        // Never both elements at once: a bi-colour lamp would show amber
        l = '{red: ph, green: ~ph};
      end
      default: begin
        l = '{red: 1'b0, green: 1'b0};
      end
    endcase
    return l;
  endfunction : paint

  // Module lamp decode, most severe first
  // A fault outranks standby: a faulty module cannot finish commissioning
  always_comb begin
    if (module_cond_i.self_test) begin
      module_state_indication = status_lamp_pkg::IND_RED_GREEN;
    end else if (module_cond_i.major_fault) begin
      module_state_indication = status_lamp_pkg::IND_RED;
    end else if (module_cond_i.minor_fault) begin
      module_state_indication = status_lamp_pkg::IND_FLASH_RED;
    end else if (module_cond_i.standby) begin
      module_state_indication = status_lamp_pkg::IND_FLASH_GREEN;
    end else begin
      module_state_indication = status_lamp_pkg::IND_GREEN;
    end
  end

  // Network lamp decode, most severe first
  // Duplicate address or bus-off is tested ahead of on-line: such a node is
  // never on-line, and a dark lamp would hide a critical link failure.
  // Timeout sits above the green states so a lost I/O connection is not
  // masked by other connections that are still established.
  always_comb begin
    if (module_cond_i.self_test) begin
      network_state_indication = status_lamp_pkg::IND_RED_GREEN;
    end else if (network_cond_i.dup_address || network_cond_i.bus_off) begin
      network_state_indication = status_lamp_pkg::IND_RED;
    end else if (!network_cond_i.online) begin
      network_state_indication = status_lamp_pkg::IND_OFF;
    end else if (network_cond_i.io_timeout) begin
      network_state_indication = status_lamp_pkg::IND_FLASH_RED;
    end else if (network_cond_i.group2_only) begin
      // Allocation stands in for connection on a group 2 slave
      network_state_indication = network_cond_i.allocated ? status_lamp_pkg::IND_GREEN
                                                          : status_lamp_pkg::IND_FLASH_GREEN;
    end else if (network_cond_i.conn_established) begin
      network_state_indication = status_lamp_pkg::IND_GREEN;
    end else begin
      network_state_indication = status_lamp_pkg::IND_FLASH_GREEN;
    end
  end

  // Next state: timers, heartbeat and lamp colours
  // A half period of zero wraps through the whole timer range, so keep both
  // half periods at one cycle or more.
  always_comb begin
    next_state = state;
    // Shared flash timebase for both bi-colour lamps
    // The timer runs from reset on, whatever the lamps show
    if (state.flash_timer == FLASH_LAST) begin
      next_state.flash_timer = status_lamp_pkg::TIMER_RESET;
      next_state.phase = ~state.phase;
    end else begin
      next_state.flash_timer = state.flash_timer + 1'b1;
    end
    // Heartbeat freezes at its level when the link fails
    // An idle board freezes it too, so a stuck board shows a steady lamp
    if (board_running_i && link_ok_i) begin
      if (state.beat_timer == BEAT_LAST) begin
        next_state.beat_timer = status_lamp_pkg::TIMER_RESET;
        next_state.beat = ~state.beat;
      end else begin
        next_state.beat_timer = state.beat_timer + 1'b1;
      end
    end
    // Painted with the current phase, so lamps lag the phase bit by one clock
    next_state.module_lamp = paint(module_state_indication, state.phase);
    next_state.network_lamp = paint(network_state_indication, state.phase);
  end

  // State register
  // Asynchronous reset clears every field: lamps dark, timers and phase zero
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // Outputs straight from flip-flops
  assign heartbeat_lamp_o = state.beat;
  assign module_state_lamp_o = state.module_lamp;
  assign network_state_lamp_o = state.network_lamp;

  // Checks below look one clock after the inputs they decode, since every
  // lamp is painted into a flip-flop. Flashing checks compare against the
  // phase that was current when the lamp was painted, not the updated one.

  // Heartbeat holds while the link is down
  a_beat_static_link: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    !link_ok_i |=> $stable(heartbeat_lamp_o)) else $error("heartbeat moved with link down");

  // Heartbeat flips when its half period ends, and its timer restarts
  sequence s_beat_wrap;
    board_running_i && link_ok_i && (state.beat_timer == BEAT_LAST);
  endsequence
  a_beat_toggle: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    s_beat_wrap |=> (heartbeat_lamp_o != $past(heartbeat_lamp_o))
    && (state.beat_timer == status_lamp_pkg::TIMER_RESET))
    else $error("heartbeat did not flip");

  // Heartbeat level holds within a half period and while the board is idle
  a_beat_hold: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    (!board_running_i || (state.beat_timer != BEAT_LAST)) |=> $stable(heartbeat_lamp_o))
    else $error("heartbeat moved early");

  // Heartbeat timer freezes while the board is idle or the link is down
  a_beat_timer_freeze: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    (!board_running_i || !link_ok_i) |=> $stable(state.beat_timer))
    else $error("heartbeat timer ran while frozen");

  // Operational module shows steady green
  a_module_green_ok: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    (module_cond_i == '0) |=> (module_state_lamp_o == 2'b01)) else $error("module lamp not green");

  // Standby never shows red; green follows the phase it was painted with
  a_module_standby_flash: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    (module_cond_i == 4'b0001) |=> (module_state_lamp_o.green == $past(state.phase) && !module_state_lamp_o.red))
    else $error("standby lamp wrong");

  // Minor fault without self test or major fault flashes red
  sequence s_minor_only;
    !module_cond_i.self_test && !module_cond_i.major_fault && module_cond_i.minor_fault;
  endsequence
  a_module_minor_flash: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    s_minor_only |=> (module_state_lamp_o.red == $past(state.phase) && !module_state_lamp_o.green))
    else $error("minor fault lamp wrong");

  // Major fault steady red
  a_module_major_red: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    (!module_cond_i.self_test && module_cond_i.major_fault) |=> (module_state_lamp_o == 2'b10))
    else $error("major fault not red");

  // Self test alternates in the shared phase, never both lit
  sequence s_self_test;
    module_cond_i.self_test;
  endsequence
  a_self_test_alt: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    s_self_test |=> (module_state_lamp_o.red ^ module_state_lamp_o.green)
    && (module_state_lamp_o.red == $past(state.phase))
    && (network_state_lamp_o == module_state_lamp_o)) else $error("self test pattern wrong");

  // No pattern ever lights both elements: the lamp would look amber
  a_lamp_no_amber: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    !(module_state_lamp_o.red && module_state_lamp_o.green)
    && !(network_state_lamp_o.red && network_state_lamp_o.green))
    else $error("lamp shows both colours");

  // Not on-line keeps network lamp dark
  a_net_dark_offline: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    (!module_cond_i.self_test && !network_cond_i.online && !network_cond_i.dup_address && !network_cond_i.bus_off)
    |=> (network_state_lamp_o == 2'b00)) else $error("network lamp lit offline");

  // Duplicate address or bus-off steady red
  a_net_critical_red: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    (!module_cond_i.self_test && (network_cond_i.dup_address || network_cond_i.bus_off))
    |=> (network_state_lamp_o == 2'b10)) else $error("critical link not red");

  // Timeout flashes red only
  a_net_timeout_red: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    (!module_cond_i.self_test && network_cond_i.online && network_cond_i.io_timeout
     && !network_cond_i.dup_address && !network_cond_i.bus_off)
    |=> (network_state_lamp_o.red == $past(state.phase) && !network_state_lamp_o.green)) else $error("timeout lamp wrong");

  // On-line with nothing wrong and no connection flashes green
  sequence s_net_waiting;
    !module_cond_i.self_test && !network_cond_i.dup_address && !network_cond_i.bus_off && network_cond_i.online
    && !network_cond_i.io_timeout && !network_cond_i.group2_only && !network_cond_i.conn_established;
  endsequence
  a_net_online_flash: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    s_net_waiting |=> (network_state_lamp_o.green == $past(state.phase) && !network_state_lamp_o.red))
    else $error("on-line lamp not flashing green");

  // Group 2 slave not yet allocated flashes green
  sequence s_group2_free;
    !module_cond_i.self_test && !network_cond_i.dup_address && !network_cond_i.bus_off && network_cond_i.online
    && !network_cond_i.io_timeout && network_cond_i.group2_only && !network_cond_i.allocated;
  endsequence
  a_net_group2_flash: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    s_group2_free |=> (network_state_lamp_o.green == $past(state.phase) && !network_state_lamp_o.red))
    else $error("unallocated lamp not flashing green");

  // Group 2 slave allocated to a master shows steady green
  sequence s_group2_held;
    !module_cond_i.self_test && !network_cond_i.dup_address && !network_cond_i.bus_off && network_cond_i.online
    && !network_cond_i.io_timeout && network_cond_i.group2_only && network_cond_i.allocated;
  endsequence
  a_net_group2_green: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    s_group2_held |=> (network_state_lamp_o == 2'b01)) else $error("allocated lamp not green");

  // Established connection steady green
  a_net_conn_green: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    (!module_cond_i.self_test && network_cond_i.online && !network_cond_i.io_timeout && !network_cond_i.group2_only
     && network_cond_i.conn_established && !network_cond_i.dup_address && !network_cond_i.bus_off)
    |=> (network_state_lamp_o == 2'b01)) else $error("connected lamp not green");

  // Flash phase toggles exactly at the half period
  a_phase_period: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    (state.flash_timer == FLASH_LAST) |=> (state.phase != $past(state.phase))) else $error("flash phase stuck");

  // Between wraps the phase holds, so every half period has its full length
  a_phase_hold: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    (state.flash_timer != FLASH_LAST) |=> $stable(state.phase)) else $error("flash phase moved early");

  // Both timers stay within their half period
  a_timer_bound: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    (state.flash_timer <= FLASH_LAST) && (state.beat_timer <= BEAT_LAST))
    else $error("timer out of range");

endmodule : status_led_indicator_logic

// File: status_led_indicator_logic_bench.sv
// Testbench: lamp patterns for each module and network condition
`timescale 1ns/10ps
module status_led_indicator_logic_bench;
  logic ref_clk_i = 1'b0; // Board clock
  logic rstn_i = 1'b0; // Reset, active low
  logic run = 1'b0; // Board running
  logic link = 1'b0; // Link healthy
  status_lamp_pkg::module_cond_type mc = 4'h0; // Module conditions
  status_lamp_pkg::network_cond_type nc = 7'h00; // Network conditions
  logic hb; // Heartbeat lamp
  status_lamp_pkg::lamp_type ml; // Module lamp
  status_lamp_pkg::lamp_type nl; // Network lamp
  logic [3:0] mr, mg, mb, nr, ng, nb, hg; // Viewer counts
  int fail_count = 0; // Mismatches
  int tests_run = 0; // Comparisons
  // Clock at 250 MHz
  always #2 ref_clk_i = ~ref_clk_i;
  // Short half periods keep one flash period at eight clocks
  status_led_indicator_logic #(.HEARTBEAT_HALF(4), .FLASH_HALF(4)) i_dut (.ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i), .board_running_i(run), .link_ok_i(link), .module_cond_i(mc), .network_cond_i(nc),
    .heartbeat_lamp_o(hb), .module_state_lamp_o(ml), .network_state_lamp_o(nl));
  status_lamp_viewer i_mv (.ref_clk_i(ref_clk_i), .lamp_i(ml), .red_cnt_o(mr), .green_cnt_o(mg), .both_cnt_o(mb));
  status_lamp_viewer i_nv (.ref_clk_i(ref_clk_i), .lamp_i(nl), .red_cnt_o(nr), .green_cnt_o(ng), .both_cnt_o(nb));
  status_lamp_viewer i_hv (.ref_clk_i(ref_clk_i), .lamp_i({1'b0, hb}), .red_cnt_o(), .green_cnt_o(hg),
    .both_cnt_o());
  // Compare and report
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  // Apply levels at the falling edge, then let the window refill
  task automatic settle(input logic [3:0] m, input logic [6:0] n);
    mc = m;
    nc = n;
    repeat (12) @(negedge ref_clk_i);
  endtask : settle
  // Verdict
  task automatic summarize;
    $display("Checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize
  // Heartbeat blinks, then freezes on link loss
  task automatic t_heartbeat;
    run = 1'b1;
    link = 1'b1;
    settle(4'h0, 7'h00);
    check("heartbeat duty", hg, 4'h4);
    link = 1'b0;
    settle(4'h0, 7'h00);
    check("heartbeat frozen", 4'((hg == 4'h0) || (hg == 4'h8)), 4'h1);
    link = 1'b1;
    run = 1'b0;
    settle(4'h0, 7'h00);
    check("heartbeat idle", 4'((hg == 4'h0) || (hg == 4'h8)), 4'h1);
    run = 1'b1;
    settle(4'h0, 7'h00);
    check("heartbeat resumes", hg, 4'h4);
  endtask : t_heartbeat
  // Module lamp states, faults stacked to test priority
  task automatic t_module;
    settle(4'h0, 7'h00);
    check("ms green", {mr, mg}, 8'h08);
    settle(4'h1, 7'h00);
    check("ms standby", {mr, mg}, 8'h04);
    settle(4'h3, 7'h00);
    check("ms minor", {mr, mg}, 8'h40);
    settle(4'h7, 7'h00);
    check("ms major", {mr, mg}, 8'h80);
  endtask : t_module
  // Self test wins over every other condition on both lamps
  task automatic t_self_test;
    settle(4'hF, 7'h7F);
    check("ms self test", {mr, mg}, 8'h44);
    check("ms no amber", mb, 4'h0);
    check("ns self test", {nr, ng}, 8'h44);
    check("ns no amber", nb, 4'h0);
  endtask : t_self_test
  // Network lamp states walked through a table
  task automatic t_network;
    logic [6:0] cond [9] = '{7'h00, 7'h08, 7'h40, 7'h60, 7'h48, 7'h70, 7'h4C, 7'h42, 7'h01};
    logic [7:0] want [9] = '{8'h00, 8'h00, 8'h04, 8'h04, 8'h08, 8'h08, 8'h40, 8'h80, 8'h80};
    for (int i = 0; i < 9; i++) begin
      settle(4'h0, cond[i]);
      check($sformatf("ns case %0d", i), {nr, ng}, want[i]);
    end
  endtask : t_network
  // Both green flashes run in step from one timebase
  task automatic t_timebase;
    logic [3:0] same;
    same = 4'h0;
    settle(4'h1, 7'h40);
    for (int i = 0; i < 8; i++) begin
      same = same + 4'(ml.green === nl.green);
      @(negedge ref_clk_i);
    end
    check("shared phase", same, 4'h8);
  endtask : t_timebase
  // Reset in mid-run darkens every lamp; the first edge after release decodes again
  task automatic t_reset;
    settle(4'h0, 7'h48);
    rstn_i = 1'b0;
    repeat (3) @(negedge ref_clk_i);
    check("reset dark", {hb, ml, nl}, 8'h00);
    rstn_i = 1'b1;
    @(negedge ref_clk_i);
    check("first edge", {hb, ml, nl}, 8'h05);
  endtask : t_reset
  // Main sequence
  initial begin
    repeat (20) @(negedge ref_clk_i);
    rstn_i = 1'b1;
    t_heartbeat();
    t_module();
    t_self_test();
    t_network();
    t_timebase();
    t_reset();
    summarize();
  end
  // Watchdog well beyond the expected run length
  initial begin
    #40000;
    fail_count++;
    summarize();
  end
endmodule : status_led_indicator_logic_bench
